// ==== pkg/vgo_defines.svh ====
// offsets, field positions, reset values and timing counts of the config and fault block
`ifndef VGO_DEFINES_SVH
`define VGO_DEFINES_SVH

`define VGO_CMD_MODE        8'h34
`define VGO_CMD_VIN_RISE    8'h35
`define VGO_CMD_VIN_FALL    8'h36
`define VGO_CMD_OV_LIMIT    8'h40
`define VGO_CMD_OV_ACTION   8'h41
`define VGO_PAGE_ONLY       8'h00

`define VGO_MODE_MAX_EFF    8'h00
`define VGO_MODE_MAX_POWER  8'h03
`define VGO_MODE_MFR        8'h04

`define VGO_RST_MODE        8'h03
`define VGO_RST_VIN_RISE    16'h030C
`define VGO_RST_VIN_FALL    16'h0000
`define VGO_RST_OV_LIMIT    16'h0C1C
`define VGO_RST_OV_ACTION   8'h84

`define VGO_ACT_HI          7
`define VGO_ACT_LO          6
`define VGO_RETRY_HI        5
`define VGO_RETRY_LO        3
`define VGO_DELAY_HI        2
`define VGO_DELAY_LO        0
`define VGO_ACT_CONTINUE    2'h0
`define VGO_ACT_DISABLE     2'h2
`define VGO_RETRY_NONE      3'h0
`define VGO_RETRY_FOREVER   3'h7

`define VGO_OV_MAX_MV       18'h00BEA
`define VGO_OV_HYST_MV      18'h00064
`define VGO_DELAY_STEP_MS   8'h19
`define VGO_DELAY_MAX_MS    8'hAF

`define VGO_CLK_PERIOD_PS   4000
`define VGO_MS_PS           1000000000
`define VGO_CYC_PER_MS      (`VGO_MS_PS / `VGO_CLK_PERIOD_PS)

`endif

// ==== pkg/vgo_pkg.sv ====
// types shared by the config and fault block
package vgo_pkg;

    typedef enum logic [3:0] {
        VGO_ST_OFF   = 4'b0001,
        VGO_ST_RUN   = 4'b0010,
        VGO_ST_LATCH = 4'b0100,
        VGO_ST_WAIT  = 4'b1000
    } vgo_state_t;

    typedef logic signed [17:0] vgo_level_t;

endpackage

// ==== src/vgo_hyst.sv ====
// level detector with separate set and clear thresholds
`timescale 1ns/1ps
module vgo_hyst
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    // level and thresholds
    input  wire vgo_pkg::vgo_level_t level_i,
    input  wire vgo_pkg::vgo_level_t set_thr_i,
    input  wire vgo_pkg::vgo_level_t clr_thr_i,
    // detector state
    output logic                   active_o
);
    import vgo_pkg::*;

    logic active_r;
    logic active_nxt;

    always_comb
    begin
        active_nxt = active_r;
        if (!active_r && (level_i >= set_thr_i))
        begin
            active_nxt = 1'b1;
        end
        else if (active_r && (level_i <= clr_thr_i))
        begin
            active_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            active_r <= 1'b0;
        end
        else
        begin
            active_r <= active_nxt;
        end
    end

    assign active_o = active_r;
endmodule

// ==== src/vgo_tick.sv ====
// divider giving a one-cycle pulse each millisecond
`timescale 1ns/1ps
module vgo_tick
#(
    parameter int CYC_PER_MS = 250000
)
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // realign the period
    input  wire logic restart_i,
    // millisecond pulse
    output logic      tick_o
);
    import vgo_pkg::*;

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r + 32'h1;
        tick_nxt = 1'b0;
        if (restart_i)
        begin
            cnt_nxt = 32'h0;
        end
        else if (cnt_r >= 32'(CYC_PER_MS - 1))
        begin
            cnt_nxt  = 32'h0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule

// ==== src/vgo_fault_cfg.sv ====
// configuration registers, input gating and overvoltage response of the rail
//
// Overview of operation
// - mode codes 00h, 03h, 04h decoded
// - modes 0 and 4 drop voltage immediately
// - mode 3 uses programmed turn-off delay/fall
// - mode register resets to 03h
// - enable only after vin reaches turn-on
// - disable when vin falls to turn-off
// - vin thresholds are signed two's complement
// - vout compared to unsigned limit, 1mV
// - usable limit spans 0 to 3050mV
// - fault clears after 100mV drop
// - action bits 7:6, 00 continue, 10 disable
// - fault pulls alert low, sets status
// - retry 000 latches output off
// - retry 111 restarts without limit
// - delay bits 2:0, 25ms per LSB
// - action register resets to 84h
`include "vgo_defines.svh"
`timescale 1ns/1ps
module vgo_fault_cfg
#(
    parameter int CYC_PER_MS = `VGO_CYC_PER_MS
)
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // command port
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  page_i,
    input  wire logic        wr_en_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        rd_en_i,
    output logic [15:0]      rd_data_o,
    output logic             rd_valid_o,
    output logic             wr_ack_o,
    output logic             wr_nack_o,
    // rail control and measurement
    input  wire logic        run_i,
    input  wire logic        bias_ok_i,
    input  wire logic        other_fault_i,
    input  wire logic [15:0] vin_level_i,
    input  wire logic [15:0] vout_mv_i,
    input  wire logic        clear_fault_i,
    // rail state
    output logic             out_enable_o,
    output logic             down_immediate_o,
    output logic             down_programmed_o,
    output logic             ov_status_o,
    output logic             alert_out_n_o,
    output vgo_pkg::vgo_state_t rail_state_o
);
    import vgo_pkg::*;

    logic [7:0]  mode_r,    mode_nxt;
    logic [15:0] von_r,     von_nxt;
    logic [15:0] voff_r,    voff_nxt;
    logic [15:0] ovlim_r,   ovlim_nxt;
    logic [7:0]  action_r,  action_nxt;
    logic [15:0] rdata_r,   rdata_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic        ack_r,     ack_nxt;
    logic        nack_r,    nack_nxt;
    logic        wr_ok;

    vgo_state_t  st_r,      st_nxt;
    logic [7:0]  wait_r,    wait_nxt;
    logic        oven_r,    oven_nxt;
    logic        dimm_r,    dimm_nxt;
    logic        dprog_r,   dprog_nxt;
    logic        ovst_r,    ovst_nxt;
    logic        alert_r,   alert_nxt;
    logic        ovq_r,     ovq_nxt;
    logic        ov_act;
    logic        vin_ok;
    logic        ms_tick;
    logic        ov_set;
    logic        may_run;
    vgo_level_t  ov_lim_eff;
    logic [1:0]  act_fld;
    logic [2:0]  retry_fld;
    logic [2:0]  delay_fld;

    assign act_fld   = action_r[`VGO_ACT_HI:`VGO_ACT_LO];
    assign retry_fld = action_r[`VGO_RETRY_HI:`VGO_RETRY_LO];
    assign delay_fld = action_r[`VGO_DELAY_HI:`VGO_DELAY_LO];

    assign ov_lim_eff = ({2'b00, ovlim_r} > `VGO_OV_MAX_MV) ? `VGO_OV_MAX_MV
                                                           : {2'b00, ovlim_r};

    vgo_hyst u_vin_gate
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .level_i    ({{2{vin_level_i[15]}}, vin_level_i}),
        .set_thr_i  ({{2{von_r[15]}}, von_r}),
        .clr_thr_i  ({{2{voff_r[15]}}, voff_r}),
        .active_o   (vin_ok)
    );

    vgo_hyst u_ov_det
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .level_i    ({2'b00, vout_mv_i}),
        .set_thr_i  (ov_lim_eff + 18'sh00001),
        .clr_thr_i  (ov_lim_eff - `VGO_OV_HYST_MV),
        .active_o   (ov_act)
    );

    vgo_tick #(.CYC_PER_MS(CYC_PER_MS)) u_ms
    (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (st_r != VGO_ST_WAIT),
        .tick_o     (ms_tick)
    );

    assign wr_ok = wr_en_i && (page_i == `VGO_PAGE_ONLY);

    // command decode
    always_comb
    begin
        mode_nxt   = mode_r;
        von_nxt    = von_r;
        voff_nxt   = voff_r;
        ovlim_nxt  = ovlim_r;
        action_nxt = action_r;
        ack_nxt    = 1'b0;
        nack_nxt   = 1'b0;
        rdata_nxt  = 16'h0000;
        rvalid_nxt = rd_en_i;
        if (wr_en_i && !wr_ok)
        begin
            nack_nxt = 1'b1;
        end
        else if (wr_ok && cmd_code_i == `VGO_CMD_MODE)
        begin
            if (wr_data_i[7:0] == `VGO_MODE_MAX_EFF || wr_data_i[7:0] == `VGO_MODE_MAX_POWER
                || wr_data_i[7:0] == `VGO_MODE_MFR)
            begin
                mode_nxt = wr_data_i[7:0];
                ack_nxt  = 1'b1;
            end
            else
            begin
                nack_nxt = 1'b1;
            end
        end
        else if (wr_ok && cmd_code_i == `VGO_CMD_VIN_RISE)
        begin
            von_nxt = wr_data_i;
            ack_nxt = 1'b1;
        end
        else if (wr_ok && cmd_code_i == `VGO_CMD_VIN_FALL)
        begin
            voff_nxt = wr_data_i;
            ack_nxt  = 1'b1;
        end
        else if (wr_ok && cmd_code_i == `VGO_CMD_OV_LIMIT)
        begin
            ovlim_nxt = wr_data_i;
            ack_nxt   = 1'b1;
        end
        else if (wr_ok && cmd_code_i == `VGO_CMD_OV_ACTION)
        begin
            if ((wr_data_i[7:6] == `VGO_ACT_CONTINUE || wr_data_i[7:6] == `VGO_ACT_DISABLE)
                && (wr_data_i[5:3] == `VGO_RETRY_NONE || wr_data_i[5:3] == `VGO_RETRY_FOREVER))
            begin
                action_nxt = wr_data_i[7:0];
                ack_nxt    = 1'b1;
            end
            else
            begin
                nack_nxt = 1'b1;
            end
        end
        else if (wr_ok)
        begin
            nack_nxt = 1'b1;
        end
        if (rd_en_i && cmd_code_i == `VGO_CMD_MODE)
        begin
            rdata_nxt = {8'h00, mode_r};
        end
        else if (rd_en_i && cmd_code_i == `VGO_CMD_VIN_RISE)
        begin
            rdata_nxt = von_r;
        end
        else if (rd_en_i && cmd_code_i == `VGO_CMD_VIN_FALL)
        begin
            rdata_nxt = voff_r;
        end
        else if (rd_en_i && cmd_code_i == `VGO_CMD_OV_LIMIT)
        begin
            rdata_nxt = ovlim_r;
        end
        else if (rd_en_i && cmd_code_i == `VGO_CMD_OV_ACTION)
        begin
            rdata_nxt = {8'h00, action_r};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            mode_r   <= `VGO_RST_MODE;
            von_r    <= `VGO_RST_VIN_RISE;
            voff_r   <= `VGO_RST_VIN_FALL;
            ovlim_r  <= `VGO_RST_OV_LIMIT;
            action_r <= `VGO_RST_OV_ACTION;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            ack_r    <= 1'b0;
            nack_r   <= 1'b0;
        end
        else
        begin
            mode_r   <= mode_nxt;
            von_r    <= von_nxt;
            voff_r   <= voff_nxt;
            ovlim_r  <= ovlim_nxt;
            action_r <= action_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            ack_r    <= ack_nxt;
            nack_r   <= nack_nxt;
        end
    end

    assign ov_set  = ov_act && !ovq_r;
    assign may_run = run_i && bias_ok_i && !other_fault_i;

    // rail sequencing and fault response
    always_comb
    begin
        st_nxt   = st_r;
        wait_nxt = wait_r;
        ovq_nxt  = ov_act;
        // set beats a clear in the same cycle
        ovst_nxt = ov_set || (ovst_r && !clear_fault_i);
        case (st_r)
            VGO_ST_OFF:
            begin
                // start only once vin has reached turn-on and not since fallen to turn-off
                if (may_run && vin_ok)
                begin
                    st_nxt = VGO_ST_RUN;
                end
            end
            VGO_ST_RUN:
            begin
                // drop out on low vin or stop
                if (!may_run || !vin_ok)
                begin
                    st_nxt = VGO_ST_OFF;
                end
                // only action 10 interrupts the rail
                else if (ov_set && act_fld == `VGO_ACT_DISABLE)
                begin
                    // 25ms per step, 111 is 175ms
                    if (retry_fld == `VGO_RETRY_FOREVER)
                    begin
                        st_nxt   = VGO_ST_WAIT;
                        wait_nxt = 8'(delay_fld * `VGO_DELAY_STEP_MS);
                    end
                    else
                    begin
                        st_nxt = VGO_ST_LATCH;
                    end
                end
            end
            VGO_ST_LATCH:
            begin
                // held off until the rail is restarted
                if (!run_i)
                begin
                    st_nxt = VGO_ST_OFF;
                end
            end
            VGO_ST_WAIT:
            begin
                if (!may_run)
                begin
                    st_nxt = VGO_ST_OFF;
                end
                else if (wait_r == 8'h00)
                begin
                    st_nxt = vin_ok ? VGO_ST_RUN : VGO_ST_OFF;
                end
                else if (ms_tick)
                begin
                    wait_nxt = wait_r - 8'h01;
                end
            end
            default:
            begin
                st_nxt = VGO_ST_OFF;
            end
        endcase
        oven_nxt  = (st_nxt == VGO_ST_RUN);
        // efficiency and vendor modes decay at once
        dimm_nxt  = (mode_r != `VGO_MODE_MAX_POWER);
        dprog_nxt = (mode_r == `VGO_MODE_MAX_POWER);
        alert_nxt = !ovst_nxt;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r    <= VGO_ST_OFF;
            wait_r  <= 8'h00;
            ovq_r   <= 1'b0;
            ovst_r  <= 1'b0;
            oven_r  <= 1'b0;
            dimm_r  <= 1'b0;
            dprog_r <= 1'b1;
            alert_r <= 1'b1;
        end
        else
        begin
            st_r    <= st_nxt;
            wait_r  <= wait_nxt;
            ovq_r   <= ovq_nxt;
            ovst_r  <= ovst_nxt;
            oven_r  <= oven_nxt;
            dimm_r  <= dimm_nxt;
            dprog_r <= dprog_nxt;
            alert_r <= alert_nxt;
        end
    end

    assign rd_data_o         = rdata_r;
    assign rd_valid_o        = rvalid_r;
    assign wr_ack_o          = ack_r;
    assign wr_nack_o         = nack_r;
    assign out_enable_o      = oven_r;
    assign down_immediate_o  = dimm_r;
    assign down_programmed_o = dprog_r;
    assign ov_status_o       = ovst_r;
    assign alert_out_n_o     = alert_r;
    assign rail_state_o      = st_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_trip_retry;
        st_r == VGO_ST_RUN && may_run && vin_ok && ov_set && act_fld == `VGO_ACT_DISABLE
            && retry_fld == `VGO_RETRY_FOREVER;
    endsequence

    sequence s_off_for_delay;
        (!out_enable_o && st_r == VGO_ST_WAIT && wait_r == $past(delay_fld) * 8'h19);
    endsequence

    a_mode_reset: assert property ($fell(sys_rst_i) |-> mode_r == 8'h03)
        else $error("mode register not 03h after reset");
    a_action_reset: assert property ($fell(sys_rst_i) |-> action_r == 8'h84)
        else $error("action register not 84h after reset");
    a_down_select: assert property (mode_r == 8'h03 && $stable(mode_r) |->
        down_programmed_o && !down_immediate_o)
        else $error("max power mode not using programmed ramp down");
    a_vin_gate: assert property ($rose(out_enable_o) |-> $past(vin_ok))
        else $error("output enabled below turn-on threshold");
    a_vin_drop: assert property (st_r == VGO_ST_RUN && !vin_ok |=> !out_enable_o)
        else $error("output still enabled after input fell");
    a_ov_alert: assert property (ov_set |=> !alert_out_n_o && ov_status_o)
        else $error("overvoltage did not raise alert and status");
    a_latch_hold: assert property (st_r == VGO_ST_LATCH && run_i |=>
        st_r == VGO_ST_LATCH && !out_enable_o)
        else $error("latched rail left latch while still commanded on");
    a_retry_entry: assert property (s_trip_retry |=> s_off_for_delay)
        else $error("retry wait not entered with selected delay");
    a_wait_done: assert property (st_r == VGO_ST_WAIT && wait_r == 8'h00 && may_run && vin_ok
        |=> st_r == VGO_ST_RUN ##1 out_enable_o || st_r != VGO_ST_RUN)
        else $error("restart not attempted after delay");
    a_nack_hold: assert property (wr_nack_o |->
        mode_r == $past(mode_r) && action_r == $past(action_r))
        else $error("refused write changed a register");
endmodule

// ==== bench/vgo_host_model.sv ====
// host model issuing configuration commands to the config and fault block
`timescale 1ns/1ps
module vgo_host_model
(
    // clock
    input  wire logic        core_clk_i,
    // answers from the device
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_valid_i,
    input  wire logic        wr_ack_i,
    input  wire logic        wr_nack_i,
    // requests to the device
    output logic [7:0]       cmd_code_o,
    output logic [7:0]       page_o,
    output logic             wr_en_o,
    output logic [15:0]      wr_data_o,
    output logic             rd_en_o
);
    initial
    begin
        cmd_code_o = 8'h00;
        page_o     = 8'h00;
        wr_en_o    = 1'b0;
        wr_data_o  = 16'h0000;
        rd_en_o    = 1'b0;
    end

    // page is a caller choice so that refusals can be provoked
    task automatic write_cmd(input logic [7:0] cmd, input logic [7:0] page,
                             input logic [15:0] data, output logic [1:0] resp);
        @(negedge core_clk_i);
        cmd_code_o = cmd;
        page_o     = page;
        wr_data_o  = data;
        wr_en_o    = 1'b1;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        resp      = {wr_ack_i, wr_nack_i};
        wr_en_o   = 1'b0;
        // stale data would hide a missing qualifier
        wr_data_o = ~data;
        page_o    = 8'h00;
    endtask

    task automatic read_cmd(input logic [7:0] cmd, output logic [15:0] data,
                            output logic valid);
        @(negedge core_clk_i);
        cmd_code_o = cmd;
        page_o     = 8'h00;
        rd_en_o    = 1'b1;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        data    = rd_data_i;
        valid   = rd_valid_i;
        rd_en_o = 1'b0;
    endtask
endmodule

// ==== bench/test_vgo_fault_cfg.sv ====
// self-checking bench of the config and fault block
`timescale 1ns/1ps
module test_vgo_fault_cfg;
    import vgo_pkg::*;
    localparam int CPM = 10;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  page;
        logic [15:0] data;
        logic        ack;
        logic [15:0] rd;
    } vgo_tb_row_t;

    logic core_clk_i, sys_rst_i, run_i, bias_ok_i, other_fault_i, clear_fault_i;
    logic [15:0] vin_level_i, vout_mv_i, rd_data_o, wr_data_i, rdat;
    logic [7:0]  cmd_code_i, page_i;
    logic wr_en_i, rd_en_i, rd_valid_o, wr_ack_o, wr_nack_o, rval;
    logic out_enable_o, down_immediate_o, down_programmed_o, ov_status_o, alert_out_n_o;
    logic [1:0]  resp;
    vgo_state_t  rail_state_o;
    int n_errors = 0;
    int n_checks = 0;
    int i, n, exp_n;
    logic [7:0]  rst_cmd [5] = '{8'h34, 8'h35, 8'h36, 8'h40, 8'h41};
    logic [15:0] rst_val [5] = '{16'h0003, 16'h030C, 16'h0000, 16'h0C1C, 16'h0084};
    logic [2:0]  dly [3] = '{3'h0, 3'h1, 3'h7};
    vgo_tb_row_t rows [15] = '{
        '{8'h34, 8'h00, 16'h0004, 1'b1, 16'h0004}, '{8'h34, 8'h00, 16'h0000, 1'b1, 16'h0000},
        '{8'h34, 8'h00, 16'h0002, 1'b0, 16'h0000}, '{8'h34, 8'h00, 16'h0103, 1'b1, 16'h0003},
        '{8'h34, 8'h05, 16'h0000, 1'b0, 16'h0003}, '{8'h35, 8'h00, 16'hFFF0, 1'b1, 16'hFFF0},
        '{8'h36, 8'h00, 16'h8000, 1'b1, 16'h8000}, '{8'h40, 8'h00, 16'h0BB8, 1'b1, 16'h0BB8},
        '{8'h41, 8'h00, 16'h0040, 1'b0, 16'h0084}, '{8'h41, 8'h00, 16'h00C4, 1'b0, 16'h0084},
        '{8'h41, 8'h00, 16'h0088, 1'b0, 16'h0084}, '{8'h41, 8'h00, 16'h00BF, 1'b1, 16'h00BF},
        '{8'h41, 8'h00, 16'h0000, 1'b1, 16'h0000}, '{8'h41, 8'h00, 16'h0084, 1'b1, 16'h0084},
        '{8'h50, 8'h00, 16'h1234, 1'b0, 16'h0000}};

    vgo_fault_cfg #(.CYC_PER_MS(CPM)) u_vgo_fault_cfg (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cmd_code_i(cmd_code_i),
        .page_i(page_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wr_ack_o(wr_ack_o),
        .wr_nack_o(wr_nack_o), .run_i(run_i), .bias_ok_i(bias_ok_i),
        .other_fault_i(other_fault_i), .vin_level_i(vin_level_i), .vout_mv_i(vout_mv_i),
        .clear_fault_i(clear_fault_i), .out_enable_o(out_enable_o),
        .down_immediate_o(down_immediate_o), .down_programmed_o(down_programmed_o),
        .ov_status_o(ov_status_o), .alert_out_n_o(alert_out_n_o),
        .rail_state_o(rail_state_o));

    vgo_host_model u_vgo_host_model (
        .core_clk_i(core_clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
        .wr_ack_i(wr_ack_o), .wr_nack_i(wr_nack_o), .cmd_code_o(cmd_code_i),
        .page_o(page_i), .wr_en_o(wr_en_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // wide enough for valid bit plus read word
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        u_vgo_host_model.write_cmd(cmd, 8'h00, data, resp);
        check(resp, 2'b10);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (10000) @(posedge core_clk_i);
        n_errors++;
        wrap_up();
    end

    initial
    begin
        sys_rst_i = 1'b1; run_i = 1'b0; bias_ok_i = 1'b1; other_fault_i = 1'b0;
        vin_level_i = 16'h0000; vout_mv_i = 16'h0000; clear_fault_i = 1'b0;
        cycles(2);
        sys_rst_i = 1'b0;
        check({alert_out_n_o, down_programmed_o, out_enable_o}, 3'b110);
        check(rail_state_o, VGO_ST_OFF);
        for (i = 0; i < 5; i++)
        begin
            u_vgo_host_model.read_cmd(rst_cmd[i], rdat, rval);
            check({rval, rdat}, {1'b1, rst_val[i]});
        end
        for (i = 0; i < 15; i++)
        begin
            u_vgo_host_model.write_cmd(rows[i].cmd, rows[i].page, rows[i].data, resp);
            check(resp, {rows[i].ack, ~rows[i].ack});
            u_vgo_host_model.read_cmd(rows[i].cmd, rdat, rval);
            check(rdat, rows[i].rd);
            if (rows[i].cmd == 8'h34)
                check({down_immediate_o, down_programmed_o}, (rows[i].rd == 16'h3) ? 2'b01 : 2'b10);
        end
        // input window with a negative turn-off level
        wr(8'h35, 16'h02BC);
        wr(8'h36, 16'hFFF6);
        // earlier negative turn-on left the window open, close it first
        vin_level_i = 16'h8000; cycles(3);
        run_i = 1'b1; vin_level_i = 16'h02BB; cycles(5);
        check(out_enable_o, 1'b0);
        vin_level_i = 16'h02BC; cycles(3);
        check(out_enable_o, 1'b1);
        vin_level_i = 16'h0000; cycles(5);
        check(out_enable_o, 1'b1);
        vin_level_i = 16'hFFF6; cycles(3);
        check(out_enable_o, 1'b0);
        vin_level_i = 16'h02BC; cycles(3);
        // overvoltage with continue action, 1000 mV limit
        wr(8'h41, 16'h0000);
        wr(8'h40, 16'h03E8);
        vout_mv_i = 16'h03E8; cycles(3);
        check(ov_status_o, 1'b0);
        vout_mv_i = 16'h03E9; cycles(3);
        check({ov_status_o, alert_out_n_o, out_enable_o}, 3'b101);
        vout_mv_i = 16'h0385; clear_fault_i = 1'b1; cycles(1);
        clear_fault_i = 1'b0; vout_mv_i = 16'h03E9; cycles(3);
        check(ov_status_o, 1'b0);
        vout_mv_i = 16'h0384; cycles(3);
        vout_mv_i = 16'h03E9; cycles(3);
        check(ov_status_o, 1'b1);
        // limit above the usable span is capped at 3050 mV
        wr(8'h40, 16'h0FFF);
        vout_mv_i = 16'h0000; clear_fault_i = 1'b1; cycles(3);
        clear_fault_i = 1'b0; vout_mv_i = 16'h0BEA; cycles(3);
        check(ov_status_o, 1'b0);
        vout_mv_i = 16'h0BEB; cycles(3);
        check(ov_status_o, 1'b1);
        // latch off until the rail is restarted
        vout_mv_i = 16'h0000; cycles(3);
        wr(8'h41, 16'h0084);
        vout_mv_i = 16'h0FFF; cycles(3);
        check({rail_state_o, out_enable_o}, {VGO_ST_LATCH, 1'b0});
        vout_mv_i = 16'h0000; cycles(50);
        check({rail_state_o, out_enable_o}, {VGO_ST_LATCH, 1'b0});
        run_i = 1'b0; cycles(3);
        check(rail_state_o, VGO_ST_OFF);
        run_i = 1'b1; cycles(4);
        check(out_enable_o, 1'b1);
        // retry forever with delay codes 0, 1 and 7
        for (i = 0; i < 3; i++)
        begin
            wr(8'h41, {8'h00, 5'b10111, dly[i]});
            exp_n = (dly[i] == 3'h7) ? 175 * CPM : dly[i] * 25 * CPM;
            vout_mv_i = 16'h0FFF;
            n = 0;
            while (out_enable_o !== 1'b0 && n < 20)
            begin
                cycles(1);
                n++;
            end
            vout_mv_i = 16'h0000;
            n = 0;
            while (out_enable_o !== 1'b1 && n < 2000)
            begin
                cycles(1);
                n++;
            end
            check(n >= exp_n && n <= exp_n + 4, 1'b1);
        end
        // another fault stops the retry loop
        wr(8'h41, 16'h00B9);
        vout_mv_i = 16'h0FFF; cycles(3);
        vout_mv_i = 16'h0000; other_fault_i = 1'b1; cycles(300);
        check(out_enable_o, 1'b0);
        other_fault_i = 1'b0;
        wrap_up();
    end
endmodule
